// ---- rtl/duty_slew_pkg.sv ----
// constants, register map, types and lookups of the duty slew and lead angle block
// assumes a 10 MHz aclk and a 32-bit AXI4-Lite register bus
// Operation
// - a catch of a spinning motor loads duty = detected rpm / top speed / 2.
// - top speed codes 0..3 stand for 4096, 8192, 16384 and 32768 rpm.
// - outside stable closed loop, running speed is steered only by bounding the duty change per update.
// - the interval select bit picks 2.7 ms when clear and 10.8 ms when set, in acceleration and open loop only.
// - step codes 1..7 give 2,3,4,6,10,20,56 eighths; 0 is free open loop, 64 closed.
// - from DC excitation to forced commutation duty moves every 2.7 ms by the ramp step.
// - closed loop acceleration and open loop move by the running step at the chosen interval.
// - stable closed loop runs a PI update every 2.7 ms, clamped to the running step.
// - the gain select bit picks 10x/0.25 V when clear and 20x/0.125 V when set.
// - angle codes 0..8 give a fixed lead of code times 3.75 degrees.
// - angle codes 9..15 pick a six-entry lead profile indexed by frequency band.
// - band table 0 uses 100..500 Hz rising and 50..450 Hz falling; 1 or 2 doubles them.
// - without the ramp limit, soft start rises at most 8 counts per 2.7 ms.
// - the ramp step select uses the running step encoding with 0 giving 64 eighths.
package duty_slew_pkg;
	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [7:0] OFS_CFG    = 8'h00;
	localparam logic [7:0] OFS_CTRL   = 8'h04;
	localparam logic [7:0] OFS_TARGET = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_SPEED  = 8'h10;
	localparam int         CATCH_BIT  = 8;
	localparam logic [1:0] RESP_OKAY  = 2'h0;
	localparam logic [1:0] RESP_ERR   = 2'h2;

	// ************************************************************
	// timing and scaling
	// ************************************************************
	localparam int CLK_PERIOD_NS  = 100;
	localparam int STEP_SHORT_US  = 2700;
	localparam int STEP_LONG_US   = 10800;
	localparam int STEP_SHORT_CYC = (STEP_SHORT_US * 1000) / CLK_PERIOD_NS;
	localparam int STEP_LONG_CYC  = (STEP_LONG_US * 1000) / CLK_PERIOD_NS;
	localparam logic [12:0] DUTY_FULL    = 13'h1000;
	localparam logic [12:0] STEP_DEFAULT = 13'h0040;
	localparam logic [11:0] BAND_UP_BASE = 12'h064;
	localparam logic [11:0] BAND_DN_BASE = 12'h032;
	localparam logic [2:0]  BAND_TOP     = 3'h5;
	localparam logic [3:0]  FIXED_MAX    = 4'h8;
	localparam logic [23:0] INTEG_LIM    = 24'h100000;

	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [2:0] {PH_IDLE, PH_STARTUP, PH_ACCEL, PH_STABLE, PH_OPEN} phase_t;
	typedef struct packed {
		logic       ramp_limit_en;
		logic [1:0] band_table_sel;
		logic [3:0] advance_angle_sel;
		logic       sense_gain_sel;
		logic [2:0] startup_ramp_step_sel;
		logic [2:0] step_size_sel;
		logic       step_interval_sel;
		logic [1:0] top_speed_range;
	} cfg_t;
	localparam cfg_t CFG_RESET = cfg_t'(17'h00000);

	// ************************************************************
	// functions
	// ************************************************************
	// step size in eighths of a duty count
	function automatic logic [12:0] step_eighths(input logic [2:0] code);
		unique case (code)
			3'h0: step_eighths = STEP_DEFAULT;
			3'h1: step_eighths = 13'h0002;
			3'h2: step_eighths = 13'h0003;
			3'h3: step_eighths = 13'h0004;
			3'h4: step_eighths = 13'h0006;
			3'h5: step_eighths = 13'h000A;
			3'h6: step_eighths = 13'h0014;
			3'h7: step_eighths = 13'h0038;
		endcase
	endfunction : step_eighths

	// lead angle in units of 3.75 degrees, band 0 in the low nibble
	function automatic logic [3:0] lead_units(input logic [3:0] code, input logic [2:0] band);
		logic [23:0] row;
		row = 24'h000000;
		case (code)
			4'h9: row = 24'h654442;
			4'hA: row = 24'h654422;
			4'hB: row = 24'h543210;
			4'hC: row = 24'h654321;
			4'hD: row = 24'h765432;
			4'hE: row = 24'h876543;
			4'hF: row = 24'h887531;
			default: row = 24'h000000;
		endcase
		lead_units = (code <= FIXED_MAX) ? code : row[{band, 2'h0} +: 4];
	endfunction : lead_units

	// rising threshold above band k
	function automatic logic [11:0] band_up(input logic [2:0] k, input logic dbl);
		logic [11:0] v;
		v = 12'(BAND_UP_BASE * (12'(k) + 12'h001));
		band_up = dbl ? 12'(v << 1) : v;
	endfunction : band_up

	// falling threshold at the bottom of band k+1
	function automatic logic [11:0] band_dn(input logic [2:0] k, input logic dbl);
		logic [11:0] v;
		v = 12'(BAND_DN_BASE + BAND_UP_BASE * 12'(k));
		band_dn = dbl ? 12'(v << 1) : v;
	endfunction : band_dn

	// byte-lane merge of a bus write
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] ws);
		for (int i = 0; i < 4; i++) begin
			merge[i*8 +: 8] = ws[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction : merge
endpackage : duty_slew_pkg

// ---- rtl/duty_slew_and_lead_angle_ctrl.sv ----
// duty slew limiter, catch duty, PI trim and lead angle selection
// assumes rpm_in and efreq_in come synchronous from the speed detector
`timescale 1ns/1ps
module duty_slew_and_lead_angle_ctrl #(
	parameter int T_SHORT_CYC = duty_slew_pkg::STEP_SHORT_CYC,
	parameter int T_LONG_CYC  = duty_slew_pkg::STEP_LONG_CYC
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic [15:0] rpm_in,
	input  wire logic [11:0] efreq_in,
	output logic [9:0]       duty_out,
	output logic [3:0]       lead_angle_out,
	output logic [2:0]       freq_band_out,
	output logic             monitor_gain_hi
);
	// ************************************************************
	// state
	// ************************************************************
	duty_slew_pkg::cfg_t   cfg;
	duty_slew_pkg::phase_t phase;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        aw_got;
	logic        w_got;
	logic [9:0]  target_duty;
	logic [15:0] target_rpm;
	logic [12:0] duty_acc;
	logic [16:0] tick_cnt;
	logic signed [23:0] integ;
	logic [2:0]  band;

	// ************************************************************
	// bus decode
	// ************************************************************
	// write fires once address and data are both held
	wire         wr_fire   = aw_got & w_got & ~bvalid;
	wire         wr_cfg    = wr_fire & (aw_addr == duty_slew_pkg::OFS_CFG);
	wire         wr_ctrl   = wr_fire & (aw_addr == duty_slew_pkg::OFS_CTRL);
	wire         wr_target = wr_fire & (aw_addr == duty_slew_pkg::OFS_TARGET);
	wire         wr_hit    = wr_cfg | wr_ctrl | wr_target;
	wire  [31:0] cfg_word  = {15'h0000, cfg};
	wire  [31:0] tgt_word  = {target_rpm, 6'h00, target_duty};
	wire  [31:0] cfg_new   = duty_slew_pkg::merge(cfg_word, w_data, w_strb);
	wire  [31:0] tgt_new   = duty_slew_pkg::merge(tgt_word, w_data, w_strb);
	wire         phase_ok  = w_strb[0] & (w_data[2:0] <= 3'h4);
	wire         catch_fire = wr_ctrl & w_strb[1] & w_data[duty_slew_pkg::CATCH_BIT];
	wire  [31:0] stat_word = {13'h0000, band, lead_angle_out, 2'h0, duty_out};
	wire  [31:0] rd_word   =
		(araddr == duty_slew_pkg::OFS_CFG)    ? cfg_word :
		(araddr == duty_slew_pkg::OFS_CTRL)   ? {29'h0000000, phase} :
		(araddr == duty_slew_pkg::OFS_TARGET) ? tgt_word :
		(araddr == duty_slew_pkg::OFS_STATUS) ? stat_word :
		(araddr == duty_slew_pkg::OFS_SPEED)  ? {4'h0, efreq_in, rpm_in} : 32'h00000000;
	wire         rd_hit    = (araddr == duty_slew_pkg::OFS_CFG) |
		(araddr == duty_slew_pkg::OFS_CTRL) | (araddr == duty_slew_pkg::OFS_TARGET) |
		(araddr == duty_slew_pkg::OFS_STATUS) | (araddr == duty_slew_pkg::OFS_SPEED);

	// write channels, taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready  <= 1'b1;
			aw_got  <= 1'b0;
			w_got   <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h00000000;
			w_strb  <= 4'h0;
			bvalid  <= 1'b0;
			bresp   <= duty_slew_pkg::RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_addr <= awaddr;
				aw_got  <= 1'b1;
				awready <= 1'b0;
			end
			if (wvalid && wready) begin
				w_data <= wdata;
				w_strb <= wstrb;
				w_got  <= 1'b1;
				wready <= 1'b0;
			end
			if (wr_fire) begin
				bvalid <= 1'b1;
				bresp  <= wr_hit ? duty_slew_pkg::RESP_OKAY : duty_slew_pkg::RESP_ERR;
				aw_got <= 1'b0;
				w_got  <= 1'b0;
			end
			if (bvalid && bready) begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	// read channel, one answer per address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h00000000;
			rresp   <= duty_slew_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= rd_word;
			rresp   <= rd_hit ? duty_slew_pkg::RESP_OKAY : duty_slew_pkg::RESP_ERR;
		end else if (rvalid && rready) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end

	// software registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg         <= duty_slew_pkg::CFG_RESET;
			phase       <= duty_slew_pkg::PH_IDLE;
			target_duty <= 10'h000;
			target_rpm  <= 16'h0000;
		end else begin
			if (wr_cfg)
				cfg <= duty_slew_pkg::cfg_t'(cfg_new[16:0]);
			if (wr_ctrl && phase_ok)
				phase <= duty_slew_pkg::phase_t'(w_data[2:0]);
			if (wr_target) begin
				target_duty <= tgt_new[9:0];
				target_rpm  <= tgt_new[31:16];
			end
		end
	end

	// ************************************************************
	// update interval
	// ************************************************************
	// long interval only in acceleration and open loop
	wire         long_ivl = cfg.step_interval_sel &
		((phase == duty_slew_pkg::PH_ACCEL) | (phase == duty_slew_pkg::PH_OPEN));
	wire  [16:0] tick_lim = long_ivl ? 17'(T_LONG_CYC - 1) : 17'(T_SHORT_CYC - 1);
	wire         tick     = (phase != duty_slew_pkg::PH_IDLE) & (tick_cnt >= tick_lim);

	// interval counter, held at zero while idle
	always_ff @(posedge aclk) begin
		if (!aresetn || phase == duty_slew_pkg::PH_IDLE || tick)
			tick_cnt <= 17'h00000;
		else
			tick_cnt <= tick_cnt + 17'h00001;
	end

	// ************************************************************
	// step size and goal
	// ************************************************************
	// open loop code 0 is unlimited
	wire         free_run = (phase == duty_slew_pkg::PH_OPEN) & (cfg.step_size_sel == 3'h0);
	wire  [12:0] run_step = free_run ? duty_slew_pkg::DUTY_FULL :
		duty_slew_pkg::step_eighths(cfg.step_size_sel);
	wire  [12:0] ss_step  = cfg.ramp_limit_en ?
		duty_slew_pkg::step_eighths(cfg.startup_ramp_step_sel) : duty_slew_pkg::STEP_DEFAULT;
	wire  [12:0] step     = (phase == duty_slew_pkg::PH_STARTUP) ? ss_step : run_step;
	wire  [12:0] tgt_raw  = {target_duty, 3'h0};
	wire  [12:0] tgt_goal = (tgt_raw > duty_slew_pkg::DUTY_FULL) ? duty_slew_pkg::DUTY_FULL :
		tgt_raw;

	// PI trim relative to the present duty
	wire signed [17:0] err     = $signed({2'h0, target_rpm}) - $signed({2'h0, rpm_in});
	wire signed [23:0] int_sum = integ + 24'(err);
	wire signed [24:0] pi_sum  = $signed({12'h000, duty_acc}) + 25'(err >>> 2) +
		25'(integ >>> 6);
	wire  [12:0] pi_goal  = pi_sum[24] ? 13'h0000 :
		(pi_sum > $signed({12'h000, duty_slew_pkg::DUTY_FULL})) ? duty_slew_pkg::DUTY_FULL :
		pi_sum[12:0];
	wire  [12:0] goal     = (phase == duty_slew_pkg::PH_STABLE) ? pi_goal : tgt_goal;

	// bounded move toward the goal, never past 0 or full
	wire  [12:0] up_gap   = goal - duty_acc;
	wire  [12:0] dn_gap   = duty_acc - goal;
	wire  [12:0] next_acc = (goal > duty_acc) ?
		duty_acc + ((up_gap < step) ? up_gap : step) :
		duty_acc - ((dn_gap < step) ? dn_gap : step);

	// catch duty, rpm over top speed over two in eighths
	wire  [15:0] catch_raw = rpm_in >> ({1'b0, cfg.top_speed_range} + 3'h1);
	wire  [12:0] catch_val = (catch_raw > 16'(duty_slew_pkg::DUTY_FULL)) ?
		duty_slew_pkg::DUTY_FULL : catch_raw[12:0];
	wire  [12:0] acc_upd  = catch_fire ? catch_val : tick ? next_acc : duty_acc;

	// duty accumulator and its output
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			duty_acc <= 13'h0000;
			duty_out <= 10'h000;
		end else begin
			duty_acc <= acc_upd;
			duty_out <= acc_upd[12:3];
		end
	end

	// integrator runs only in stable closed loop
	always_ff @(posedge aclk) begin
		if (!aresetn || phase != duty_slew_pkg::PH_STABLE)
			integ <= 24'sh000000;
		else if (tick)
			integ <= (int_sum > $signed(duty_slew_pkg::INTEG_LIM)) ?
				$signed(duty_slew_pkg::INTEG_LIM) :
				(int_sum < -$signed(duty_slew_pkg::INTEG_LIM)) ?
				-$signed(duty_slew_pkg::INTEG_LIM) : int_sum;
	end

	// ************************************************************
	// frequency band and lead angle
	// ************************************************************
	// doubled table for any nonzero select
	wire         dbl      = |cfg.band_table_sel;
	wire  [11:0] up_thr   = duty_slew_pkg::band_up(band, dbl);
	wire  [11:0] dn_thr   = duty_slew_pkg::band_dn(band - 3'h1, dbl);
	// move one band only past the threshold of its direction
	wire  [2:0]  next_band = (band < duty_slew_pkg::BAND_TOP && efreq_in > up_thr) ?
		band + 3'h1 : (band != 3'h0 && efreq_in <= dn_thr) ? band - 3'h1 : band;

	// band, lead angle and gain select outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			band            <= 3'h0;
			freq_band_out   <= 3'h0;
			lead_angle_out  <= 4'h0;
			monitor_gain_hi <= 1'b0;
		end else begin
			band            <= next_band;
			freq_band_out   <= next_band;
			lead_angle_out  <= duty_slew_pkg::lead_units(cfg.advance_angle_sel, band);
			monitor_gain_hi <= cfg.sense_gain_sel;
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic [12:0] acc_prev_q;

	// duty one edge back, for the step size checks
	always_ff @(posedge aclk) begin
		acc_prev_q <= duty_acc;
	end

	wire [12:0] acc_delta  = (duty_acc > acc_prev_q) ? duty_acc - acc_prev_q :
		acc_prev_q - duty_acc;

	duty_sat_a: assert property (duty_acc <= duty_slew_pkg::DUTY_FULL)
		else $error("duty above full");
	duty_hold_a: assert property (!tick && !catch_fire |=> $stable(duty_acc))
		else $error("duty moved off an update");
	catch_mid_a: assert property (catch_fire && cfg.top_speed_range == 2'h2 &&
		rpm_in < 16'h4000 |=> duty_acc == 13'($past(rpm_in) >> 3))
		else $error("catch duty wrong");
	catch_low_a: assert property (catch_fire && cfg.top_speed_range == 2'h0 &&
		rpm_in < 16'h2000 |=> duty_acc == 13'($past(rpm_in) >> 1))
		else $error("catch duty wrong at low top speed");
	long_ivl_a: assert property (phase == duty_slew_pkg::PH_OPEN &&
		cfg.step_interval_sel && tick |-> tick_cnt >= 17'(T_LONG_CYC - 1))
		else $error("long interval too short");
	ss_ivl_a: assert property (phase == duty_slew_pkg::PH_STARTUP &&
		$past(phase) == duty_slew_pkg::PH_STARTUP && tick |-> tick_cnt == 17'(T_SHORT_CYC - 1))
		else $error("startup interval wrong");
	ss_step_a: assert property ($past(tick) && $past(phase) == duty_slew_pkg::PH_STARTUP &&
		!$past(cfg.ramp_limit_en) && !$past(catch_fire) |-> acc_delta <= 13'h0040)
		else $error("soft start step too large");
	ramp_sel_a: assert property ($past(tick) && $past(phase) == duty_slew_pkg::PH_STARTUP &&
		$past(cfg.ramp_limit_en) && $past(cfg.startup_ramp_step_sel) == 3'h1 &&
		!$past(catch_fire) |-> acc_delta <= 13'h0002)
		else $error("ramp step too large");
	run_step_a: assert property ($past(phase) == duty_slew_pkg::PH_ACCEL &&
		$past(cfg.step_size_sel) == 3'h3 && !$past(catch_fire) |-> acc_delta <= 13'h0004)
		else $error("running step too large");
	pi_clamp_a: assert property ($past(phase) == duty_slew_pkg::PH_STABLE &&
		$past(cfg.step_size_sel) == 3'h5 && !$past(catch_fire) |-> acc_delta <= 13'h000A)
		else $error("PI step not clamped");
	lead_fix_a: assert property (cfg.advance_angle_sel <= 4'h8 &&
		$stable(cfg.advance_angle_sel) |=> lead_angle_out == $past(cfg.advance_angle_sel))
		else $error("fixed lead wrong");
	lead_prof_a: assert property (cfg.advance_angle_sel == 4'hF && band == 3'h5 &&
		$stable(band) |=> lead_angle_out == 4'h8)
		else $error("lead profile wrong");
	band_edge_a: assert property (band == 3'h0 && cfg.band_table_sel == 2'h1 &&
		efreq_in == 12'h0C9 |=> band == 3'h1)
		else $error("doubled band edge missed");
	band_hyst_a: assert property (band == 3'h1 && cfg.band_table_sel == 2'h0 &&
		efreq_in > 12'h032 && efreq_in <= 12'h0C8 |=> band == 3'h1)
		else $error("band left inside hysteresis");
	gain_sel_a: assert property ($rose(cfg.sense_gain_sel) |=> monitor_gain_hi [*2])
		else $error("gain select not followed");

	catch_c: cover property (catch_fire);
	pi_tick_c: cover property (tick && phase == duty_slew_pkg::PH_STABLE);
	band_top_c: cover property (band == duty_slew_pkg::BAND_TOP);
	free_run_c: cover property (tick && free_run ##1 acc_delta > 13'h0040);
endmodule : duty_slew_and_lead_angle_ctrl

// ---- verification/motor_model.sv ----
// far-side model: inverter plus motor, gives detected speed and electrical frequency
// assumes the bench sets coasting speeds while spin_en is low
`timescale 1ns/1ps
module motor_model (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [9:0]  duty,
	input  wire logic        spin_en,
	input  wire logic [15:0] rpm_set,
	input  wire logic [11:0] efreq_set,
	output logic      [15:0] rpm,
	output logic      [11:0] efreq
);
	// ************************************************************
	// speed
	// ************************************************************
	// driven motor follows duty one cycle late, coasting motor keeps the set speed
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rpm   <= 16'h0000;
			efreq <= 12'h000;
		end else if (spin_en) begin
			rpm   <= {duty, 6'h00};
			efreq <= {duty, 2'h0};
		end else begin
			rpm   <= rpm_set;
			efreq <= efreq_set;
		end
	end
endmodule : motor_model

// ---- verification/testbench.sv ----
// self-checking bench of the duty slew and lead angle block over AXI4-Lite
// assumes short tick parameters 20 and 80 cycles and the motor model beside it
`timescale 1ns/1ps
module testbench;
	localparam int TS = 20;
	localparam int W8 = 8 * TS + TS / 2;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, spin_en;
	logic        awready, wready, bvalid, arready, rvalid, monitor_gain_hi;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0]  wstrb, lead_angle_out;
	logic [1:0]  bresp, rresp, rs;
	logic [15:0] rpm_in, rpm_set;
	logic [11:0] efreq_in, efreq_set;
	logic [9:0]  duty_out;
	logic [2:0]  freq_band_out;
	int          n_errors, samples_checked;
	logic [9:0]  steps [8] = '{10'h040, 10'h002, 10'h003, 10'h004, 10'h006, 10'h00A,
		10'h014, 10'h038};
	logic [3:0]  lo [7] = '{4'h2, 4'h2, 4'h0, 4'h1, 4'h2, 4'h3, 4'h1};
	logic [3:0]  hi [7] = '{4'h6, 4'h6, 4'h5, 4'h6, 4'h7, 4'h8, 4'h8};
	logic [3:0]  prof [6] = '{4'h1, 4'h3, 4'h5, 4'h7, 4'h8, 4'h8};
	logic [1:0]  bsel [11] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2};
	logic [11:0] bf [11] = '{12'h000, 12'h096, 12'h050, 12'h032, 12'h065, 12'h258, 12'h1CC,
		12'h1B8, 12'h1B8, 12'h24E, 12'h262};
	logic [2:0]  bexp [11] = '{3'h0, 3'h1, 3'h1, 3'h0, 3'h1, 3'h5, 3'h5, 3'h4, 3'h2, 3'h2, 3'h3};

	duty_slew_and_lead_angle_ctrl #(.T_SHORT_CYC(20), .T_LONG_CYC(80)) dut_u (.aclk(aclk),
		.aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .rpm_in(rpm_in), .efreq_in(efreq_in),
		.duty_out(duty_out), .lead_angle_out(lead_angle_out), .freq_band_out(freq_band_out),
		.monitor_gain_hi(monitor_gain_hi));
	motor_model motor_u (.aclk(aclk), .aresetn(aresetn), .duty(duty_out), .spin_en(spin_en),
		.rpm_set(rpm_set), .efreq_set(efreq_set), .rpm(rpm_in), .efreq(efreq_in));

	// ************************************************************
	// tasks
	// ************************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// each channel released as it is taken, then wait for the response
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask : wr

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		// no cycle count assumed: waits for rvalid, and only the watchdog ends a hang
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd_reg

	// stop in idle with zero duty, configure, start a phase and sample mid-interval
	task automatic ramp(input logic [31:0] cfg, input logic [31:0] ph, input int cyc,
		input logic [31:0] exp);
		logic [1:0] r;
		wr(duty_slew_pkg::OFS_CTRL, 32'h0000_0100, r);
		wr(duty_slew_pkg::OFS_CFG, cfg, r);
		wr(duty_slew_pkg::OFS_TARGET, 32'h4000_0200, r);
		wr(duty_slew_pkg::OFS_CTRL, ph, r);
		repeat (cyc) @(posedge aclk);
		check(32'(duty_out), exp);
	endtask : ramp

	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : stop_test

	// ************************************************************
	// clock, watchdog and tests
	// ************************************************************
	// free-running 10 MHz clock
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	// hang guard, well beyond the expected run
	initial begin
		repeat (40000) @(posedge aclk);
		n_errors++;
		stop_test();
	end

	// main sequence
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, spin_en} = 6'h00;
		aresetn = 1'b0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0000_0000;
		wstrb = 4'hF;
		rpm_set = 16'h04D2;
		efreq_set = 12'h000;
		n_errors = 0;
		samples_checked = 0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rd_reg(duty_slew_pkg::OFS_CFG, rd, rs);
		check(rd, 32'h0000_0000);
		check(32'(monitor_gain_hi), 32'h0);
		wr(duty_slew_pkg::OFS_CFG, 32'h0000_0200, rs);
		@(posedge aclk);
		check(32'(monitor_gain_hi), 32'h1);
		rd_reg(8'h14, rd, rs);
		check(32'(rs), 32'(duty_slew_pkg::RESP_ERR));
		rd_reg(duty_slew_pkg::OFS_SPEED, rd, rs);
		check(32'(rd[15:0]), 32'h04D2);
		$display("test registers done");
		rpm_set <= 16'h0BB8;
		for (int k = 0; k < 4; k++) begin
			wr(duty_slew_pkg::OFS_CFG, 32'(k), rs);
			wr(duty_slew_pkg::OFS_CTRL, 32'h0000_0100, rs);
			@(posedge aclk);
			check(32'(duty_out), 32'(16'h0BB8 >> (k + 4)));
		end
		rpm_set <= 16'hEA60;
		wr(duty_slew_pkg::OFS_CFG, 32'h0000_0000, rs);
		wr(duty_slew_pkg::OFS_CTRL, 32'h0000_0100, rs);
		@(posedge aclk);
		check(32'(duty_out), 32'h0000_0200);
		rpm_set <= 16'h0000;
		$display("test catch done");
		for (int c = 1; c < 8; c++) ramp(32'(c << 3), 32'h4, W8, 32'(steps[c]));
		ramp(32'h0000_0000, 32'h4, 30, 32'h0000_0200);
		ramp(32'h0000_0000, 32'h2, W8, 32'h0000_0040);
		ramp(32'h0000_003C, 32'h4, W8, 32'h0000_000E);
		ramp(32'h0000_001C, 32'h2, W8, 32'h0000_0001);
		for (int c = 0; c < 8; c++) ramp(32'h1002C | 32'(c << 6), 32'h1, W8, 32'(steps[c]));
		ramp(32'h0000_002C, 32'h1, W8, 32'h0000_0040);
		ramp(32'h0000_002C, 32'h3, W8, 32'h0000_000A);
		rd_reg(duty_slew_pkg::OFS_STATUS, rd, rs);
		check(32'(rd[9:0]), 32'h0000_000A);
		$display("test slew done");
		efreq_set <= 12'h2BC;
		for (int c = 0; c < 9; c++) begin
			wr(duty_slew_pkg::OFS_CFG, 32'(c << 10), rs);
			repeat (3) @(posedge aclk);
			check(32'(lead_angle_out), 32'(c));
		end
		for (int c = 9; c < 16; c++) begin
			efreq_set <= 12'h000;
			wr(duty_slew_pkg::OFS_CFG, 32'(c << 10), rs);
			repeat (10) @(posedge aclk);
			check(32'(lead_angle_out), 32'(lo[c - 9]));
			efreq_set <= 12'h7D0;
			repeat (10) @(posedge aclk);
			check(32'(lead_angle_out), 32'(hi[c - 9]));
		end
		for (int i = 0; i < 11; i++) begin
			wr(duty_slew_pkg::OFS_CFG, 32'h3C00 | (32'(bsel[i]) << 14), rs);
			efreq_set <= bf[i];
			repeat (10) @(posedge aclk);
			check(32'(freq_band_out), 32'(bexp[i]));
			check(32'(lead_angle_out), 32'(prof[bexp[i]]));
		end
		$display("test lead angle done");
		// PI pushes a driven motor into the full-duty bound
		ramp(32'h0000_0000, 32'h0, 2, 32'h0000_0000);
		spin_en <= 1'b1;
		wr(duty_slew_pkg::OFS_TARGET, 32'hFFFF_0200, rs);
		wr(duty_slew_pkg::OFS_CTRL, 32'h0000_0003, rs);
		repeat (64 * TS + 200) @(posedge aclk);
		check(32'(duty_out), 32'h0000_0200);
		check(32'(duty_out <= 10'h200), 32'h1);
		$display("test driven motor done");
		stop_test();
	end
endmodule : testbench
